/* File: core/rmii_pkg.sv */
package rmii_pkg;
  // ********************************************************
  // Timing of the sampling clock and of the reference clock
  // ********************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int REF_PERIOD_NS = 800;
  localparam int REF_HALF_CYCLES = REF_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] REF_HALF_LAST = 4'(REF_HALF_CYCLES - 1);
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  // At 10 Mbps every dibit spans ten reference cycles
  localparam int SLOW_REPEAT = 10;
  localparam logic [3:0] SLOW_REPEAT_LAST = 4'(SLOW_REPEAT - 1);

  // ********************************************************
  // Data values and buffer shape
  // ********************************************************
  localparam logic [1:0] IDLE_DIBIT = 2'h0;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL_COUNT = 2'h2;
  localparam logic [1:0] BUF_EMPTY_COUNT = 2'h0;
endpackage

/* File: core/rmii_link_if.sv */
`timescale 1ns/10ps
interface rmii_link_if;
  logic ref_clk_out;
  logic crystal_input_pin;
  logic ref_clk;
  logic tx_en;
  logic [1:0] txd;
  logic crs_dv;
  logic [1:0] rxd;
  logic rx_er;

  // Only one source drives its clock line; the unused one is held low
  assign ref_clk = ref_clk_out | crystal_input_pin;

  modport phy
  (
    output ref_clk_out,
    input crystal_input_pin,
    input ref_clk,
    input tx_en,
    input txd,
    output crs_dv,
    output rxd,
    output rx_er
  );

  modport mac
  (
    input ref_clk,
    output crystal_input_pin,
    output tx_en,
    output txd,
    input crs_dv,
    input rxd,
    input rx_er
  );
endinterface

/* File: core/rmii_phy_end.sv */
`timescale 1ns/10ps
module rmii_phy_end
  import rmii_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic XTAL_BUILD,
  input wire logic SPEED_100,
  rmii_link_if.phy LINK,
  output logic TX_VALID,
  output logic [1:0] TX_DIBIT,
  output logic TX_ACTIVE,
  input wire logic RX_CARRIER,
  input wire logic RX_VALID,
  input wire logic [1:0] RX_DIBIT,
  output logic RX_READY,
  input wire logic RX_ERROR
);
  // ********************************************************
  // Reference clock source
  // ********************************************************
  logic xtal_reg;
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic gen_clk_reg;
  logic gen_clk_next;
  logic div_wrap;
  logic gen_rise;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic ext_clk_d_reg;
  logic ext_rise;
  logic ref_edge;

  assign div_wrap = div_reg == REF_HALF_LAST;
  assign div_next = div_wrap ? COUNT_ZERO : div_reg + COUNT_ONE;
  assign gen_clk_next = div_wrap ? ~gen_clk_reg : gen_clk_reg;
  // Act one cycle after the generated clock rises so the partner still
  // samples the old data at that rise
  assign gen_rise = gen_clk_reg & (div_reg == COUNT_ZERO);
  assign ext_rise = sync2_reg[3] & ~ext_clk_d_reg;
  assign ref_edge = xtal_reg ? gen_rise : ext_rise;
  assign LINK.ref_clk_out = xtal_reg & gen_clk_reg;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      xtal_reg <= XTAL_BUILD;
      div_reg <= COUNT_ZERO;
      gen_clk_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      gen_clk_reg <= gen_clk_next;
    end
  end

  // Pins from the partner pass two flops before any use
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      ext_clk_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {LINK.ref_clk, LINK.tx_en, LINK.txd};
      sync2_reg <= sync1_reg;
      ext_clk_d_reg <= sync2_reg[3];
    end
  end

  // ********************************************************
  // Transmit path
  // ********************************************************
  logic tx_en_s;
  logic [1:0] txd_s;
  logic [3:0] tx_cnt_reg;
  logic [3:0] tx_cnt_next;
  logic tx_take;

  assign tx_en_s = sync2_reg[2];
  assign txd_s = sync2_reg[1:0];
  // Slow mode takes the first edge of each ten-edge dibit
  assign tx_take = ref_edge & tx_en_s & (SPEED_100 | tx_cnt_reg == COUNT_ZERO);
  // Counting restarts whenever enable is low, so each frame aligns itself
  assign tx_cnt_next = (~tx_en_s | tx_cnt_reg == SLOW_REPEAT_LAST) ? COUNT_ZERO
                       : tx_cnt_reg + COUNT_ONE;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      tx_cnt_reg <= COUNT_ZERO;
      TX_VALID <= 1'b0;
      TX_DIBIT <= IDLE_DIBIT;
      TX_ACTIVE <= 1'b0;
    end
    else
    begin
      TX_VALID <= tx_take;
      if (ref_edge)
      begin
        tx_cnt_reg <= tx_cnt_next;
        TX_ACTIVE <= tx_en_s;
      end
      if (tx_take)
      begin
        TX_DIBIT <= txd_s;
      end
    end
  end

  // ********************************************************
  // Receive buffer, two entries
  // ********************************************************
  logic [1:0] buf_mem [BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic buf_full;
  logic buf_empty;
  logic push;
  logic pop;

  assign buf_full = count_reg == BUF_FULL_COUNT;
  assign buf_empty = count_reg == BUF_EMPTY_COUNT;
  assign RX_READY = ~buf_full;
  assign push = RX_VALID & ~buf_full;
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge CLK)
  begin
    if (push)
    begin
      buf_mem[wr_ptr_reg] <= RX_DIBIT;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= BUF_EMPTY_COUNT;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg <= count_next;
    end
  end

  // ********************************************************
  // Receive signalling
  // ********************************************************
  logic carrier_reg;
  logic [1:0] rxd_reg;
  logic rx_er_reg;
  logic err_pend_reg;
  logic err_pend_next;
  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_cnt_next;
  logic rx_slot;
  logic carrier_end;
  logic carrier_next;

  assign rx_slot = ref_edge & (SPEED_100 | rx_cnt_reg == COUNT_ZERO);
  assign rx_cnt_next = (~carrier_reg | rx_cnt_reg == SLOW_REPEAT_LAST) ? COUNT_ZERO
                       : rx_cnt_reg + COUNT_ONE;
  // Sense is held until every buffered dibit has been sent
  assign carrier_end = rx_slot & ~RX_CARRIER & buf_empty;
  // Rises in any sampling cycle, not waiting for a reference edge
  assign carrier_next = RX_CARRIER | (carrier_reg & ~carrier_end);
  assign pop = rx_slot & carrier_reg & ~buf_empty;
  // A new error outranks the clear of one being reported
  assign err_pend_next = (RX_ERROR & carrier_reg) | (err_pend_reg & ~rx_slot);

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      carrier_reg <= 1'b0;
      rxd_reg <= IDLE_DIBIT;
      rx_er_reg <= 1'b0;
      err_pend_reg <= 1'b0;
      rx_cnt_reg <= COUNT_ZERO;
    end
    else
    begin
      carrier_reg <= carrier_next;
      err_pend_reg <= err_pend_next;
      if (ref_edge)
      begin
        rx_cnt_reg <= rx_cnt_next;
      end
      if (rx_slot)
      begin
        // Empty buffer means nothing decoded yet, so idle shows
        rxd_reg <= pop ? buf_mem[rd_ptr_reg] : IDLE_DIBIT;
        rx_er_reg <= carrier_reg & ~carrier_end & (err_pend_reg | RX_ERROR);
      end
    end
  end

  assign LINK.crs_dv = carrier_reg;
  assign LINK.rxd = rxd_reg;
  assign LINK.rx_er = rx_er_reg;
endmodule

/* File: core/rmii_mac_end.sv */
`timescale 1ns/10ps
module rmii_mac_end
  import rmii_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SUPPLY_CLK,
  input wire logic SPEED_100,
  rmii_link_if.mac LINK,
  input wire logic TX_VALID,
  input wire logic [1:0] TX_DIBIT,
  output logic TX_READY,
  output logic RX_VALID,
  output logic [1:0] RX_DIBIT,
  output logic RX_ERROR,
  output logic RX_CARRIER
);
  // ********************************************************
  // Reference clock source
  // ********************************************************
  logic supply_reg;
  logic [3:0] div_reg;
  logic gen_clk_reg;
  logic div_wrap;
  logic gen_rise;
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic ext_clk_d_reg;
  logic ext_rise;
  logic ref_edge;

  assign div_wrap = div_reg == REF_HALF_LAST;
  assign gen_rise = gen_clk_reg & (div_reg == COUNT_ZERO);
  assign ext_rise = sync2_reg[4] & ~ext_clk_d_reg;
  assign ref_edge = supply_reg ? gen_rise : ext_rise;
  assign LINK.crystal_input_pin = supply_reg & gen_clk_reg;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      supply_reg <= SUPPLY_CLK;
      div_reg <= COUNT_ZERO;
      gen_clk_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_wrap ? COUNT_ZERO : div_reg + COUNT_ONE;
      gen_clk_reg <= gen_clk_reg ^ div_wrap;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      ext_clk_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {LINK.ref_clk, LINK.crs_dv, LINK.rxd, LINK.rx_er};
      sync2_reg <= sync1_reg;
      ext_clk_d_reg <= sync2_reg[4];
    end
  end

  // ********************************************************
  // Transmit buffer and pins
  // ********************************************************
  logic [1:0] buf_mem [BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;
  logic buf_empty;
  logic tx_en_reg;
  logic [1:0] txd_reg;
  logic [3:0] tx_cnt_reg;
  logic tx_slot;

  assign buf_empty = count_reg == BUF_EMPTY_COUNT;
  assign TX_READY = count_reg != BUF_FULL_COUNT;
  assign push = TX_VALID & TX_READY;
  // Enable follows buffer content, so a frame ends when the user stops
  assign tx_slot = ref_edge & (SPEED_100 | tx_cnt_reg == COUNT_ZERO);
  assign pop = tx_slot & ~buf_empty;

  always_ff @(posedge CLK)
  begin
    if (push)
    begin
      buf_mem[wr_ptr_reg] <= TX_DIBIT;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= BUF_EMPTY_COUNT;
      tx_en_reg <= 1'b0;
      txd_reg <= IDLE_DIBIT;
      tx_cnt_reg <= COUNT_ZERO;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      if (ref_edge)
      begin
        // A pop at count zero starts the count at once, so the first dibit
        // of a frame stands the full ten edges as well
        tx_cnt_reg <= (tx_cnt_reg == COUNT_ZERO) ? {3'h0, pop}
                      : (tx_cnt_reg == SLOW_REPEAT_LAST) ? COUNT_ZERO
                      : tx_cnt_reg + COUNT_ONE;
      end
      if (tx_slot)
      begin
        tx_en_reg <= ~buf_empty;
        txd_reg <= buf_empty ? IDLE_DIBIT : buf_mem[rd_ptr_reg];
      end
    end
  end

  assign LINK.tx_en = tx_en_reg;
  assign LINK.txd = txd_reg;

  // ********************************************************
  // Receive sampling
  // ********************************************************
  logic crs_s;
  logic [3:0] rx_cnt_reg;
  logic rx_slot;

  assign crs_s = sync2_reg[3];
  assign rx_slot = ref_edge & crs_s & (SPEED_100 | rx_cnt_reg == COUNT_ZERO);

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      rx_cnt_reg <= COUNT_ZERO;
      RX_VALID <= 1'b0;
      RX_DIBIT <= IDLE_DIBIT;
      RX_ERROR <= 1'b0;
      RX_CARRIER <= 1'b0;
    end
    else
    begin
      RX_VALID <= rx_slot;
      RX_CARRIER <= crs_s;
      if (ref_edge)
      begin
        rx_cnt_reg <= (~crs_s | rx_cnt_reg == SLOW_REPEAT_LAST) ? COUNT_ZERO
                      : rx_cnt_reg + COUNT_ONE;
      end
      if (rx_slot)
      begin
        RX_DIBIT <= sync2_reg[2:1];
        RX_ERROR <= sync2_reg[0];
      end
    end
  end
endmodule

/* File: tb/rmii_link_props.sv */
`timescale 1ns/10ps
module rmii_link_props
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic ref_clk_out,
  input wire logic crystal_input_pin,
  input wire logic ref_clk,
  input wire logic tx_en,
  input wire logic [1:0] txd,
  input wire logic crs_dv,
  input wire logic [1:0] rxd,
  input wire logic rx_er
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // ****************
  // Reference clock
  // ****************
  property p_one_source;
    !(ref_clk_out && crystal_input_pin);
  endproperty
  a_one_source: assert property (p_one_source)
    else $error("two clock sources at once");
  property p_clk_high;
    $rose(ref_clk) |-> ref_clk [*4] ##1 !ref_clk;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("reference clock high phase wrong");
  // ****************
  // Transfers
  // ****************
  property p_tx_idle;
    !tx_en |-> txd == 2'h0;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("transmit data not idle");
  // Window is a cycle loose: the sampling end adds flop delay
  property p_tx_sync;
    $changed({tx_en, txd}) |-> $past(ref_clk) || $past(ref_clk, 2) || $past(ref_clk, 3);
  endproperty
  a_tx_sync: assert property (p_tx_sync)
    else $error("transmit pins moved off the clock");
  property p_rx_idle;
    !crs_dv |-> rxd == 2'h0;
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("receive data not idle");
  property p_er_idle;
    !crs_dv |-> !rx_er;
  endproperty
  a_er_idle: assert property (p_er_idle)
    else $error("receive error without carrier");
  property p_rx_sync;
    $changed({rxd, rx_er}) |-> $past(ref_clk) || $past(ref_clk, 2) || $past(ref_clk, 3);
  endproperty
  a_rx_sync: assert property (p_rx_sync)
    else $error("receive pins moved off the clock");
  property p_crs_rise;
    $rose(crs_dv) |-> rxd == 2'h0 && !rx_er;
  endproperty
  a_crs_rise: assert property (p_crs_rise)
    else $error("data present as carrier rose");
  c_tx_frame: cover property ($rose(tx_en));
  c_rx_frame: cover property ($rose(crs_dv));
  c_rx_error: cover property (crs_dv && rx_er);
endmodule

/* File: tb/tb_rmii_phy_mac_port.sv */
`timescale 1ns/10ps
module tb_rmii_phy_mac_port;
  import rmii_pkg::*;
  // ****************
  // Ends and link
  // ****************
  localparam int LIMIT = 3000;
  localparam int GAP = 2 * REF_HALF_CYCLES;
  logic clk, reset, xtal_build, supply_clk, speed_100;
  logic mtx_valid, mtx_ready, ptx_valid, ptx_active;
  logic prx_carrier, prx_valid, prx_ready, prx_error;
  logic mrx_valid, mrx_error, mrx_carrier;
  logic [1:0] mtx_dibit, ptx_dibit, prx_dibit, mrx_dibit;
  logic [1:0] tx_pat[6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1};
  logic [1:0] rx_pat[4] = '{2'h3, 2'h1, 2'h2, 2'h3};
  logic [1:0] tx_got[$];
  logic [1:0] rx_got[$];
  int num_errors = 0, total_checks = 0, err_seen = 0, cyc = 0, tx_last = 0, tx_gap = 0;
  int tx_on = 0;
  rmii_link_if link();
  rmii_phy_end u_rmii_phy_end
  (
    .CLK(clk), .RESET(reset), .XTAL_BUILD(xtal_build), .SPEED_100(speed_100),
    .LINK(link.phy), .TX_VALID(ptx_valid), .TX_DIBIT(ptx_dibit), .TX_ACTIVE(ptx_active),
    .RX_CARRIER(prx_carrier), .RX_VALID(prx_valid), .RX_DIBIT(prx_dibit),
    .RX_READY(prx_ready), .RX_ERROR(prx_error)
  );
  rmii_mac_end u_rmii_mac_end
  (
    .CLK(clk), .RESET(reset), .SUPPLY_CLK(supply_clk), .SPEED_100(speed_100),
    .LINK(link.mac), .TX_VALID(mtx_valid), .TX_DIBIT(mtx_dibit), .TX_READY(mtx_ready),
    .RX_VALID(mrx_valid), .RX_DIBIT(mrx_dibit), .RX_ERROR(mrx_error),
    .RX_CARRIER(mrx_carrier)
  );
  rmii_link_props u_rmii_link_props
  (
    .CLK(clk), .RESET(reset), .ref_clk_out(link.ref_clk_out),
    .crystal_input_pin(link.crystal_input_pin), .ref_clk(link.ref_clk),
    .tx_en(link.tx_en), .txd(link.txd), .crs_dv(link.crs_dv), .rxd(link.rxd),
    .rx_er(link.rx_er)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (ptx_valid === 1'b1)
    begin
      tx_got.push_back(ptx_dibit);
      tx_gap = cyc - tx_last;
      tx_last = cyc;
    end
    if (mrx_valid === 1'b1)
    begin
      rx_got.push_back(mrx_dibit);
      if (mrx_error === 1'b1)
        err_seen++;
    end
    if (link.tx_en === 1'b1)
      tx_on++;
    cyc++;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic summarize();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic ran_out(input int n);
    if (n >= LIMIT)
    begin
      check(1'b0, "wait ran out");
      summarize();
    end
  endtask
  task automatic do_reset(input logic x, input logic s, input logic sp);
    reset = 1'b1;
    xtal_build = x;
    supply_clk = s;
    speed_100 = sp;
    repeat (12) tick();
    reset = 1'b0;
    tx_got.delete();
    rx_got.delete();
    err_seen = 0;
    tx_on = 0;
  endtask
  // Ready is read just after an edge, once the buffer count has settled
  task automatic push(input bit rx);
    int n;
    for (n = 0; n < LIMIT && (rx ? prx_ready : mtx_ready) !== 1'b1; n++) tick();
    ran_out(n);
    tick();
  endtask
  task automatic tx_frame();
    foreach (tx_pat[i])
    begin
      mtx_valid = 1'b1;
      mtx_dibit = tx_pat[i];
      push(1'b0);
    end
    mtx_valid = 1'b0;
    mtx_dibit = 2'h0;
  endtask
  task automatic rx_frame();
    prx_carrier = 1'b1;
    foreach (rx_pat[i])
    begin
      prx_valid = 1'b1;
      prx_dibit = rx_pat[i];
      prx_error = (i == 1);
      push(1'b1);
    end
    prx_valid = 1'b0;
    prx_error = 1'b0;
    prx_carrier = 1'b0;
  endtask
  task automatic judge_tx(input int gap);
    int n;
    for (n = 0; n < LIMIT && (tx_got.size() < 6 || ptx_active !== 1'b0); n++) tick();
    ran_out(n);
    foreach (tx_pat[i]) check(tx_got[i] === tx_pat[i], "transmit dibit");
    check(tx_got.size() == 6, "extra transmit dibit");
    check(tx_gap == gap, "transmit spacing");
    // Every dibit, the first included, must stand a full slot on the wire
    check(tx_on == 6 * gap, "transmit enable length");
    check(link.tx_en === 1'b0 && link.txd === 2'h0, "transmit idle");
  endtask
  task automatic judge_rx();
    int n;
    for (n = 0; n < LIMIT && mrx_carrier !== 1'b0; n++) tick();
    ran_out(n);
    while (rx_got.size() > 0 && rx_got[0] === 2'h0) void'(rx_got.pop_front());
    check(rx_got.size() == 4, "receive count");
    foreach (rx_pat[i]) check(rx_got[i] === rx_pat[i], "receive dibit");
    check(err_seen > 0, "receive error lost");
    check(link.crs_dv === 1'b0 && link.rxd === 2'h0, "receive idle");
  endtask
  task automatic clk_src(input bit phy_src);
    int rises;
    logic prev;
    logic now;
    rises = 0;
    prev = phy_src ? link.ref_clk_out : link.crystal_input_pin;
    repeat (80)
    begin
      tick();
      now = phy_src ? link.ref_clk_out : link.crystal_input_pin;
      if (now === 1'b1 && prev === 1'b0)
        rises++;
      prev = now;
    end
    check(rises == 10, "reference clock rate");
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic s_transmit_fast();
    do_reset(1'b1, 1'b0, 1'b1);
    clk_src(1'b1);
    tx_frame();
    judge_tx(GAP);
  endtask
  task automatic s_receive_fast();
    do_reset(1'b0, 1'b1, 1'b1);
    clk_src(1'b0);
    fork
      tx_frame();
      rx_frame();
    join
    judge_tx(GAP);
    judge_rx();
  endtask
  task automatic s_duplex_slow();
    do_reset(1'b1, 1'b0, 1'b0);
    fork
      tx_frame();
      rx_frame();
    join
    judge_tx(SLOW_REPEAT * GAP);
    judge_rx();
  endtask
  initial
  begin
    reset = 1'b1;
    xtal_build = 1'b1;
    supply_clk = 1'b0;
    speed_100 = 1'b1;
    mtx_valid = 1'b0;
    mtx_dibit = 2'h0;
    prx_carrier = 1'b0;
    prx_valid = 1'b0;
    prx_dibit = 2'h0;
    prx_error = 1'b0;
    s_transmit_fast();
    s_receive_fast();
    s_duplex_slow();
    summarize();
  end
endmodule
